// ==== hdl/ppmc_apb_slave.sv ====
// APB handshake and address decode for the port mode block
`timescale 1ns/100ps
module ppmc_apb_slave
  import ppmc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  output logic                   pready_ff,
  output logic                   pslverr_ff,
  output logic                   setup,
  output logic                   addr_hit,
  output logic                   wr_take,
  output logic [3:0]             reg_idx
);

  // Decode: sixteen aligned words at the bottom of the window
  assign addr_hit = (paddr[ADDR_W-1:6] == '0) && (paddr[1:0] == 2'h0);
  assign reg_idx  = paddr[5:2];
  assign setup    = psel & ~penable;
  assign wr_take  = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  // Answer in the first access cycle; error for unmapped words
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~addr_hit;
    end
  end

endmodule // ppmc_apb_slave

// ==== hdl/ppmc_pin_driver.sv ====
// Registered pin drive for one port from its mode pair and data
`timescale 1ns/100ps
module ppmc_pin_driver
  import ppmc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] data,
  input  wire logic [WIDTH-1:0] mode_low,
  input  wire logic [WIDTH-1:0] mode_high,
  output logic [WIDTH-1:0]      pin_out_ff,
  output logic [WIDTH-1:0]      pin_oe_ff,
  output logic [WIDTH-1:0]      pin_weak_high_ff
);

  logic [WIDTH-1:0] nxt_out;
  logic [WIDTH-1:0] nxt_oe;
  logic [WIDTH-1:0] nxt_weak;

  // Per-pin drive from the high/low code pair
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    wire [2:0] drv = ppmc_drive({mode_high[i], mode_low[i]}, data[i]);
    assign nxt_oe[i]   = drv[2];
    assign nxt_out[i]  = drv[1];
    assign nxt_weak[i] = drv[0];
  end

  // Reset leaves pins floating with the weak pull-up on
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_out_ff       <= '0;
      pin_oe_ff        <= '0;
      pin_weak_high_ff <= '1;
    end else begin
      pin_out_ff       <= nxt_out;
      pin_oe_ff        <= nxt_oe;
      pin_weak_high_ff <= nxt_weak;
    end
  end

endmodule // ppmc_pin_driver

// ==== hdl/ppmc_pkg.sv ====
// Shared constants, register map and pin drive decoding for the port mode block
package ppmc_pkg;

  // Port geometry
  localparam int PPMC_PORTS  = 4;
  localparam int PPMC_PORT_W = 8;

  // Register word indices; the byte address is four times the index
  localparam logic [3:0] PPMC_IDX_DATA0 = 4'h0;  // Data latches, ports 0..3
  localparam logic [3:0] PPMC_IDX_LOW0  = 4'h4;  // Mode low registers, ports 0..3
  localparam logic [3:0] PPMC_IDX_HIGH0 = 4'h8;  // Mode high registers, ports 0..3
  localparam logic [3:0] PPMC_IDX_PIN0  = 4'hC;  // Pin level readback, ports 0..3
  localparam logic [1:0] PPMC_GRP_DATA  = 2'h0;
  localparam logic [1:0] PPMC_GRP_LOW   = 2'h1;
  localparam logic [1:0] PPMC_GRP_HIGH  = 2'h2;

  // Reset values: latches high, every pin quasi-bidirectional
  localparam logic [7:0] PPMC_RST_DATA = 8'hFF;
  localparam logic [7:0] PPMC_RST_LOW  = 8'hFF;
  localparam logic [7:0] PPMC_RST_HIGH = 8'h00;

  // Two-bit pin mode codes, high register bit first
  localparam logic [1:0] PPMC_MODE_OPEN_DRAIN = 2'h0;
  localparam logic [1:0] PPMC_MODE_QUASI      = 2'h1;
  localparam logic [1:0] PPMC_MODE_HIZ        = 2'h2;
  localparam logic [1:0] PPMC_MODE_PUSH_PULL  = 2'h3;

  // Pin that PWM channel 0 takes over
  localparam int PPMC_PWM0_PORT = 2;
  localparam int PPMC_PWM0_BIT  = 0;

  // Drive of one pin as {enable, level, weak pull-up} for a mode and data bit
  function automatic logic [2:0] ppmc_drive(input logic [1:0] code, input logic d);
    case (code)
      PPMC_MODE_OPEN_DRAIN: ppmc_drive = d ? 3'h0 : 3'h4;
      PPMC_MODE_QUASI:      ppmc_drive = d ? 3'h1 : 3'h4;
      PPMC_MODE_HIZ:        ppmc_drive = 3'h0;
      default:              ppmc_drive = d ? 3'h6 : 3'h4;
    endcase
  endfunction

endpackage

// ==== hdl/ppmc_top.sv ====
// Port pin mode configuration: APB registers, data latches and pin drive
//
// Notes on behaviour
// - Each of the four ports has an 8-bit mode low and an 8-bit mode high register.
// - Pin x takes its mode from bit x of the high register over bit x of the low one.
// - Code 00 makes the pin open-drain, pulled low only.
// - Code 01 makes the pin quasi-bidirectional.
// - Code 10 leaves the pin high-impedance and undriven.
// - Code 11 makes the pin a push-pull output.
// - Port 3 uses exactly the same scheme through its own register pair.
// - With PWM channel 0 enabled, its pin follows the PWM wave instead of the latch.
// - Each port has an 8-bit data latch whose bits drive the pins per their mode.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module ppmc_top
  import ppmc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              pwm_ch0_pin_takeover_enable,
  input  wire logic              pwm_ch0_wave,
  input  wire logic [7:0]        port0_pin_in,
  output logic [7:0]             port0_pin_out,
  output logic [7:0]             port0_pin_oe,
  output logic [7:0]             port0_pin_weak_high,
  input  wire logic [7:0]        port1_pin_in,
  output logic [7:0]             port1_pin_out,
  output logic [7:0]             port1_pin_oe,
  output logic [7:0]             port1_pin_weak_high,
  input  wire logic [7:0]        port2_pin_in,
  output logic [7:0]             port2_pin_out,
  output logic [7:0]             port2_pin_oe,
  output logic [7:0]             port2_pin_weak_high,
  input  wire logic [7:0]        port3_pin_in,
  output logic [7:0]             port3_pin_out,
  output logic [7:0]             port3_pin_oe,
  output logic [7:0]             port3_pin_weak_high
);

  // Register state
  logic [7:0]  data_ff  [PPMC_PORTS];
  logic [7:0]  low_ff   [PPMC_PORTS];
  logic [7:0]  high_ff  [PPMC_PORTS];
  logic [31:0] prdata_ff;

  // Pin side arrays
  logic [7:0]  pin_in_a   [PPMC_PORTS];
  logic [7:0]  pin_out_a  [PPMC_PORTS];
  logic [7:0]  pin_oe_a   [PPMC_PORTS];
  logic [7:0]  pin_weak_a [PPMC_PORTS];
  logic [7:0]  eff_data   [PPMC_PORTS];

  // Bus decode results
  logic        setup;
  logic        addr_hit;
  logic        wr_take;
  logic [3:0]  reg_idx;
  logic [1:0]  rd_grp;
  logic [1:0]  rd_port;
  logic [7:0]  rd_byte;
  logic [31:0] nxt_prdata;

  // APB handshake
  ppmc_apb_slave #(
    .ADDR_W     (ADDR_W)
  ) u_apb (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pready_ff  (pready),
    .pslverr_ff (pslverr),
    .setup      (setup),
    .addr_hit   (addr_hit),
    .wr_take    (wr_take),
    .reg_idx    (reg_idx)
  );

  // Pin inputs gathered into an array
  assign pin_in_a[0] = port0_pin_in;
  assign pin_in_a[1] = port1_pin_in;
  assign pin_in_a[2] = port2_pin_in;
  assign pin_in_a[3] = port3_pin_in;

  // Per-port registers, PWM takeover and pin driver
  for (genvar p = 0; p < PPMC_PORTS; p++) begin : g_port
    wire wr_data = wr_take && (reg_idx == PPMC_IDX_DATA0 + 4'(p));
    wire wr_low  = wr_take && (reg_idx == PPMC_IDX_LOW0 + 4'(p));
    wire wr_high = wr_take && (reg_idx == PPMC_IDX_HIGH0 + 4'(p));

    // Latch and mode pair, written only at the completing APB edge
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        data_ff[p] <= PPMC_RST_DATA;
        low_ff[p]  <= PPMC_RST_LOW;
        high_ff[p] <= PPMC_RST_HIGH;
      end else begin
        if (wr_data) data_ff[p] <= pwdata[7:0];
        if (wr_low)  low_ff[p]  <= pwdata[7:0];
        if (wr_high) high_ff[p] <= pwdata[7:0];
      end
    end

    // PWM channel 0 replaces the latch bit of its pin while enabled
    if (p == PPMC_PWM0_PORT) begin : g_pwm
      always_comb begin
        eff_data[p] = data_ff[p];
        if (pwm_ch0_pin_takeover_enable) begin
          eff_data[p][PPMC_PWM0_BIT] = pwm_ch0_wave;
        end
      end
    end else begin : g_plain
      assign eff_data[p] = data_ff[p];
    end

    // Mode decoding and registered drive, same for every port
    ppmc_pin_driver #(
      .WIDTH            (PPMC_PORT_W)
    ) u_drv (
      .sys_clk          (sys_clk),
      .resetn           (resetn),
      .data             (eff_data[p]),
      .mode_low         (low_ff[p]),
      .mode_high        (high_ff[p]),
      .pin_out_ff       (pin_out_a[p]),
      .pin_oe_ff        (pin_oe_a[p]),
      .pin_weak_high_ff (pin_weak_a[p])
    );
  end

  // Pin outputs taken from the driver flip-flops
  assign port0_pin_out       = pin_out_a[0];
  assign port0_pin_oe        = pin_oe_a[0];
  assign port0_pin_weak_high = pin_weak_a[0];
  assign port1_pin_out       = pin_out_a[1];
  assign port1_pin_oe        = pin_oe_a[1];
  assign port1_pin_weak_high = pin_weak_a[1];
  assign port2_pin_out       = pin_out_a[2];
  assign port2_pin_oe        = pin_oe_a[2];
  assign port2_pin_weak_high = pin_weak_a[2];
  assign port3_pin_out       = pin_out_a[3];
  assign port3_pin_oe        = pin_oe_a[3];
  assign port3_pin_weak_high = pin_weak_a[3];

  // Read selection by register group
  assign rd_grp  = reg_idx[3:2];
  assign rd_port = reg_idx[1:0];

  always_comb begin
    if (rd_grp == PPMC_GRP_DATA) begin
      rd_byte = data_ff[rd_port];
    end else if (rd_grp == PPMC_GRP_LOW) begin
      rd_byte = low_ff[rd_port];
    end else if (rd_grp == PPMC_GRP_HIGH) begin
      rd_byte = high_ff[rd_port];
    end else begin
      rd_byte = pin_in_a[rd_port];
    end
  end

  // Read word captured in the setup cycle; zero for writes and misses
  assign nxt_prdata = (setup && !pwrite && addr_hit) ? {24'h000000, rd_byte} : 32'h00000000;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_ff <= 32'h00000000;
    end else if (setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

  // Helper masks for the checks below
  wire [7:0] m_od0 = ~high_ff[0] & ~low_ff[0];
  wire [7:0] m_qb0 = ~high_ff[0] &  low_ff[0];
  wire [7:0] m_hz0 =  high_ff[0] & ~low_ff[0];
  wire [7:0] m_pp0 =  high_ff[0] &  low_ff[0];
  wire [7:0] m_pp3 =  high_ff[3] &  low_ff[3];
  wire [7:0] m_pp2 =  high_ff[2] &  low_ff[2];
  wire       wr_low0  = wr_take && (reg_idx == PPMC_IDX_LOW0);
  wire       wr_high3 = wr_take && (reg_idx == PPMC_IDX_HIGH0 + 4'h3);
  wire       wr_data0 = wr_take && (reg_idx == PPMC_IDX_DATA0);
  wire [7:0] m_hz1 =  high_ff[1] & ~low_ff[1];
  wire [7:0] m_od2 = ~high_ff[2] & ~low_ff[2];
  wire       wr_refused    = psel && penable && pready && pwrite && pslverr;
  wire       rd_data0      = setup && !pwrite && addr_hit && (reg_idx == PPMC_IDX_DATA0);
  wire       pwm_latch_bit = data_ff[PPMC_PWM0_PORT][PPMC_PWM0_BIT];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Mode register write lands at the completing edge
  chk_mode_low_write: assert property (
    wr_low0 |=> low_ff[0] == $past(pwdata[7:0]))
    else $error("mode low register of port 0 not updated by write");

  // Code order: high bit set, low bit clear gives a floating pin
  sequence seq_high3_set_low3_clear;
    wr_high3 && pwdata[3] && !low_ff[3][3];
  endsequence
  chk_code_order: assert property (
    seq_high3_set_low3_clear ##1 (!low_ff[3][3]) |=> !pin_oe_a[3][3] && !pin_weak_a[3][3])
    else $error("high register bit not taken as upper bit of the mode code");

  // Open-drain pulls low on zero and never drives high
  chk_open_drain_low: assert property (
    1'b1 |=> (pin_oe_a[0] & $past(m_od0)) == $past(m_od0 & ~eff_data[0])
             && (pin_out_a[0] & $past(m_od0)) == 8'h00)
    else $error("open-drain pin drove wrongly");

  // Quasi pins: strong low on zero, weak pull-up only on one
  chk_quasi_drive: assert property (
    1'b1 |=> (pin_oe_a[0] & $past(m_qb0)) == $past(m_qb0 & ~eff_data[0])
             && (pin_weak_a[0] & $past(m_qb0)) == $past(m_qb0 & eff_data[0]))
    else $error("quasi-bidirectional pin drove wrongly");

  // High-impedance pins are never driven
  chk_hiz_float: assert property (
    1'b1 |=> ((pin_oe_a[0] | pin_weak_a[0]) & $past(m_hz0)) == 8'h00)
    else $error("high-impedance pin was driven");

  // Push-pull drives the latch value on both levels
  chk_push_pull: assert property (
    1'b1 |=> (pin_oe_a[0] & $past(m_pp0)) == $past(m_pp0)
             && (pin_out_a[0] & $past(m_pp0)) == $past(m_pp0 & eff_data[0]))
    else $error("push-pull pin drove wrongly");

  // Port 3 push-pull behaves as port 0 does
  chk_port3_push: assert property (
    1'b1 |=> (pin_oe_a[3] & $past(m_pp3)) == $past(m_pp3)
             && (pin_out_a[3] & $past(m_pp3)) == $past(m_pp3 & data_ff[3]))
    else $error("port 3 push-pull pin drove wrongly");

  // PWM takeover on a push-pull pin copies the wave one cycle later
  chk_pwm_takeover: assert property (
    pwm_ch0_pin_takeover_enable && m_pp2[PPMC_PWM0_BIT]
      |=> pin_out_a[PPMC_PWM0_PORT][PPMC_PWM0_BIT] == $past(pwm_ch0_wave))
    else $error("PWM channel 0 did not control its pin");

  // Latch write reaches a push-pull pin two edges later
  sequence seq_data0_write_pp;
    wr_data0 && m_pp0[0] ##1 m_pp0[0];
  endsequence
  chk_data_to_pin: assert property (
    seq_data0_write_pp |=> pin_out_a[0][0] == $past(pwdata[0], 2))
    else $error("data latch write did not reach the pin");

  // Weak pull-up and strong drive never together on ports 0 and 3
  chk_weak_excl: assert property (
    (pin_oe_a[0] & pin_weak_a[0]) == 8'h00 && (pin_oe_a[3] & pin_weak_a[3]) == 8'h00)
    else $error("weak pull-up active while pin driven");

  // Read answer comes in the first access cycle
  chk_apb_ready: assert property (
    setup |=> pready)
    else $error("APB answer not given in first access cycle");

  // Answer is a single-cycle pulse per transfer
  chk_ready_pulse: assert property (
    pready |=> !pready)
    else $error("APB answer held longer than one cycle");

  // Error flag follows the address map and comes with the answer
  chk_slverr_map: assert property (
    setup |=> pslverr == !$past(addr_hit))
    else $error("APB error flag does not match the address map");

  // A refused write leaves latch 0 and mode low 0 untouched, whatever it aliases to
  chk_refused_write: assert property (
    wr_refused |=> data_ff[0] == $past(data_ff[0]) && low_ff[0] == $past(low_ff[0]))
    else $error("write with error response changed a register");

  // Read word carries the byte in its low bits only
  chk_read_upper: assert property (
    pready |-> prdata[31:8] == 24'h000000)
    else $error("read word has upper bits set");

  // Reading latch 0 returns the latch seen in the setup cycle
  chk_read_latch0: assert property (
    rd_data0 |=> prdata == {24'h000000, $past(data_ff[0])})
    else $error("read of data latch 0 returned a wrong word");

  // With the takeover off, the PWM pin follows its latch again
  chk_pwm_release: assert property (
    !pwm_ch0_pin_takeover_enable && m_pp2[PPMC_PWM0_BIT]
      |=> pin_out_a[PPMC_PWM0_PORT][PPMC_PWM0_BIT] == $past(pwm_latch_bit))
    else $error("PWM pin not returned to its data latch");

  // Port 1 high-impedance pins stay undriven too
  chk_port1_hiz: assert property (
    1'b1 |=> ((pin_oe_a[1] | pin_weak_a[1]) & $past(m_hz1)) == 8'h00)
    else $error("high-impedance pin of port 1 was driven");

  // Port 2 open-drain pins never drive or pull high, PWM pin included
  chk_port2_od_high: assert property (
    1'b1 |=> ((pin_out_a[2] | pin_weak_a[2]) & $past(m_od2)) == 8'h00)
    else $error("open-drain pin of port 2 drove or pulled high");

endmodule // ppmc_top

// ==== verification/ppmc_pin_model.sv ====
// Behavioural model of the circuitry hanging on one port's pins
`timescale 1ns/100ps
module ppmc_pin_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_weak_high,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_lvl,
  output logic [7:0]      pin_level
);
  logic [7:0] float_ff = 8'h5A;
  // Undriven pins wander every cycle so a stale level never passes for a drive
  always_ff @(posedge sys_clk) begin
    float_ff <= ~float_ff;
  end
  // Strong drive wins, then the external driver, then the weak pull-up
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
                   | (~pin_oe & ~ext_en & (pin_weak_high | float_ff));
endmodule // ppmc_pin_model

// ==== verification/tb_port_pin_mode_config.sv ====
// Self-checking bench for the port pin mode block
`timescale 1ns/100ps
module tb_port_pin_mode_config import ppmc_pkg::*; ;
  logic             sys_clk, resetn, psel, penable, pwrite, pwm_en, pwm_wave, err;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, rd;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr;
  wire logic [7:0]  p_out [4], p_oe [4], p_weak [4], p_in [4];
  logic [7:0]       ext_en [4], ext_lvl [4], m_data [4], m_low [4], m_high [4];
  int               n_mismatch, n_checks, seed;

  ppmc_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_ch0_pin_takeover_enable(pwm_en), .pwm_ch0_wave(pwm_wave),
    .port0_pin_in(p_in[0]), .port0_pin_out(p_out[0]), .port0_pin_oe(p_oe[0]),
    .port0_pin_weak_high(p_weak[0]), .port1_pin_in(p_in[1]), .port1_pin_out(p_out[1]),
    .port1_pin_oe(p_oe[1]), .port1_pin_weak_high(p_weak[1]), .port2_pin_in(p_in[2]),
    .port2_pin_out(p_out[2]), .port2_pin_oe(p_oe[2]), .port2_pin_weak_high(p_weak[2]),
    .port3_pin_in(p_in[3]), .port3_pin_out(p_out[3]), .port3_pin_oe(p_oe[3]),
    .port3_pin_weak_high(p_weak[3]));

  // One model of the outside circuitry per port
  for (genvar g = 0; g < 4; g++) begin : g_pins
    ppmc_pin_model pm_u (.sys_clk(sys_clk), .pin_out(p_out[g]), .pin_oe(p_oe[g]),
      .pin_weak_high(p_weak[g]), .ext_en(ext_en[g]), .ext_lvl(ext_lvl[g]),
      .pin_level(p_in[g]));
  end

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Register write with noise in the unused upper bits
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, ({$random(seed)} & 32'hFFFF_FF00) | {24'h0, d});
    check("wr_err", {31'h0, err}, 32'h0);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(a, 1'b0, 32'h0);
    check("reg_read", rd, {24'h0, e});
  endtask

  // Expected {enable, level, weak pull-up} of one pin
  function automatic logic [2:0] exp_pin(input logic [1:0] c, input logic d);
    case (c)
      2'h0:    exp_pin = d ? 3'h0 : 3'h4;
      2'h1:    exp_pin = d ? 3'h1 : 3'h4;
      2'h2:    exp_pin = 3'h0;
      default: exp_pin = d ? 3'h6 : 3'h4;
    endcase
  endfunction

  // Pin drive and readback of one port against the model registers
  task automatic check_pins(input int p);
    logic [2:0] e;
    logic [7:0] eo, ev, ew, er, mk;
    for (int b = 0; b < 8; b++) begin
      e = exp_pin({m_high[p][b], m_low[p][b]},
                  (p == 2 && b == 0 && pwm_en) ? pwm_wave : m_data[p][b]);
      {eo[b], ev[b], ew[b]} = e;
      er[b] = e[2] ? e[1] : (ext_en[p][b] ? ext_lvl[p][b] : 1'b1);
    end
    mk = eo | ext_en[p] | ew;
    check("pin_oe", {24'h0, p_oe[p]}, {24'h0, eo});
    check("pin_out", {24'h0, p_out[p] & eo}, {24'h0, ev});
    check("pin_weak", {24'h0, p_weak[p]}, {24'h0, ew});
    repeat (3) @(posedge sys_clk);
    apb(12'h030 + 12'(4 * p), 1'b0, 32'h0);
    check("readback", rd & {24'h0, mk}, {24'h0, er & mk});
  endtask

  // Configure one port, read its registers back, then check its pins
  task automatic set_port(input int p, input logic [7:0] d, l, h);
    m_data[p] = d;
    m_low[p] = l;
    m_high[p] = h;
    wr(12'(4 * p), d);
    wr(12'h010 + 12'(4 * p), l);
    wr(12'h020 + 12'(4 * p), h);
    rdchk(12'(4 * p), d);
    rdchk(12'h010 + 12'(4 * p), l);
    rdchk(12'h020 + 12'(4 * p), h);
    check_pins(p);
  endtask

  // Main sequence
  initial begin
    seed = 32'he293;
    {resetn, psel, penable, pwrite, pwm_en, pwm_wave} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_mismatch = 0;
    n_checks = 0;
    for (int p = 0; p < 4; p++) begin
      {ext_en[p], ext_lvl[p], m_data[p], m_low[p], m_high[p]} = {16'h0, 16'hFFFF, 8'h00};
    end
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    // Reset state, then every code with both data levels on every port
    for (int p = 0; p < 4; p++) begin
      rdchk(12'(4 * p), 8'hFF);
      rdchk(12'h010 + 12'(4 * p), 8'hFF);
      rdchk(12'h020 + 12'(4 * p), 8'h00);
      check_pins(p);
      set_port(p, 8'hF0, 8'hAA, 8'hCC);
    end
    // Random configurations with outside drivers
    for (int n = 0; n < 24; n++) begin
      int p;
      p = {$random(seed)} % 4;
      ext_en[p] <= 8'($random(seed));
      ext_lvl[p] <= 8'($random(seed));
      set_port(p, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    end
    // Corners: floating pin from the code order, latch into a push-pull pin
    set_port(3, 8'h00, 8'h00, 8'h08);
    set_port(0, 8'h00, 8'hFF, 8'hFF);
    set_port(0, 8'h01, 8'hFF, 8'hFF);
    // Takeover of port 2 pin 0 by the PWM wave, each code in turn
    for (int k = 0; k < 16; k++) begin
      set_port(2, 8'h5A, {4{k[0]}} ^ 8'h0F, {8{k[1]}});
      pwm_en <= k[2];
      pwm_wave <= k[3];
      @(posedge sys_clk);
      #1;
      check_pins(2);
    end
    pwm_en <= 1'b0;
    // Unmapped, misaligned and read-only places
    apb(12'h040, 1'b1, 32'h0000_0000);
    check("err_unmapped", {31'h0, err}, 32'h1);
    apb(12'h011, 1'b1, 32'h0000_0000);
    check("err_misaligned", {31'h0, err}, 32'h1);
    apb(12'h040, 1'b0, 32'h0);
    check("rd_unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(12'h030, 1'b1, 32'h0000_0000);
    check("wr_readonly", {31'h0, err}, 32'h0);
    rdchk(12'h010, m_low[0]);
    rdchk(12'h000, m_data[0]);
    tally_and_finish();
  end
endmodule // tb_port_pin_mode_config
